/* File: shared/bhl_pkg.sv */
// shared constants and types for the bus hold, lock and wait controller
package bhl_pkg;

	localparam int WAIT_W = 3;
	localparam int T2CNT_W = 4;
	localparam int SRCNT_W = 3;

	// fixed wait counts per cycle kind
	localparam logic [WAIT_W-1:0] DRAM_OFF_BASE_WAIT = 3'h2;
	localparam logic [WAIT_W-1:0] CBR_WAIT = 3'h3;
	localparam logic [WAIT_W-1:0] HALT_ACK_WAIT = 3'h0;
	localparam logic [WAIT_W-1:0] INT_IO_BASE_WAIT = 3'h1;

	// clock of the second bus state (counted from 1) at which ready is first looked at
	localparam logic [T2CNT_W-1:0] READY_CLK_DRAM_OFF = 4'h3;
	localparam logic [T2CNT_W-1:0] READY_CLK_CBR = 4'h4;
	localparam logic [T2CNT_W-1:0] READY_CLK_OTHER = 4'h1;

	// cycles of idle-mode self-refresh during which hold is refused
	localparam logic [SRCNT_W-1:0] SELF_REF_HOLD_BLOCK = 3'h6;

	// block 0 cycle type field
	localparam logic [1:0] CT0_SRAM = 2'h0;
	localparam logic [1:0] CT0_DRAM_REFRESH_REQUEST_OUT = 2'h1;
	localparam logic [1:0] CT0_IO = 2'h2;
	localparam logic [1:0] CT0_IO_DRAM_CS = 2'h3;

	// reset values of the registered outputs
	localparam logic RST_STROBE_N = 1'b1;
	localparam logic [3:0] RST_CS_N = 4'hF;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_T1 = 4'h2,
		ST_T2 = 4'h4,
		ST_HOLD = 4'h8
	} bhl_state_e;

	typedef enum logic [3:0]
	{
		KD_SRAM = 4'h0,
		KD_DRAM_OFF = 4'h1,
		KD_DRAM_ON = 4'h2,
		KD_PROM_OFF = 4'h3,
		KD_PROM_ON = 4'h4,
		KD_EXT_IO = 4'h5,
		KD_INT_IO = 4'h6,
		KD_CBR = 4'h7,
		KD_SELF_REF = 4'h8,
		KD_HALT_ACK = 4'h9,
		KD_MFAULT = 4'hA
	} bhl_kind_e;

endpackage

/* File: verilog/bhl_wait_sel.sv */
// cycle kind decode and wait count / ready selection for one bus cycle
`timescale 1ns/1ps
module bhl_wait_sel
	import bhl_pkg::*;
(
	input wire logic [1:0] block, // address block of the access
	input wire logic isIo, // access goes to i/o space
	input wire logic pageHit, // access falls in the open page
	input wire logic isCbr, // cbr refresh cycle
	input wire logic isSelfRef, // self-refresh cycle
	input wire logic isHaltAck, // halt acknowledge cycle
	input wire logic isMfault, // machine fault write cycle
	input wire logic isFlyby, // fly-by dma cycle
	input wire logic flybyCh, // fly-by dma channel
	input wire logic isDmaTwo, // two-cycle dma cycle
	input wire logic isWrite, // write cycle
	input wire logic [1:0] srcBlock, // dma source block number
	input wire logic [1:0] dstBlock, // dma destination block number
	input wire logic [1:0] ct0, // block 0 cycle type
	input wire logic ct3, // block 3 page-rom select
	input wire logic [4*WAIT_W-1:0] blockWait, // per-block wait counts
	input wire logic [2*WAIT_W-1:0] flybyWait, // per-channel fly-by wait counts
	input wire logic dramColWait, // extra off-page dram wait
	input wire logic dramPageWait, // extra on-page dram wait
	input wire logic promPageWait, // extra on-page page-rom wait
	input wire logic intIoWait, // extra internal i/o wait
	output bhl_kind_e kind, // decoded cycle kind
	output logic [WAIT_W-1:0] waitCount, // programmed or fixed waits
	output logic readyUsed, // ready pin extends this cycle
	output logic [T2CNT_W-1:0] readyClk // first t2 clock at which ready counts
);
	logic [1:0] waitBlock;
	logic [WAIT_W-1:0] dramOff;
	logic [WAIT_W-1:0] flyW;

	always_comb
	begin
		if (isHaltAck)
			kind = KD_HALT_ACK;
		else if (isSelfRef)
			kind = KD_SELF_REF;
		else if (isCbr)
			kind = KD_CBR;
		else if (isMfault)
			kind = KD_MFAULT;
		else if (isIo)
			kind = (block == 2'h3) ? KD_INT_IO : KD_EXT_IO;
		else if (block == 2'h0 && ct0[0])
			kind = pageHit ? KD_DRAM_ON : KD_DRAM_OFF;
		else if (block == 2'h3 && ct3)
			kind = pageHit ? KD_PROM_ON : KD_PROM_OFF;
		else
			kind = KD_SRAM;
	end

	always_comb
	begin
		waitBlock = isDmaTwo ? (isWrite ? dstBlock : srcBlock) : block;
		dramOff = DRAM_OFF_BASE_WAIT + WAIT_W'(dramColWait);
		flyW = flybyWait[flybyCh*WAIT_W +: WAIT_W];
		readyClk = READY_CLK_OTHER;
		readyUsed = 1'b0;
		waitCount = blockWait[waitBlock*WAIT_W +: WAIT_W];
		case (kind)
			KD_HALT_ACK: waitCount = HALT_ACK_WAIT;
			KD_SELF_REF: waitCount = '0;
			KD_CBR:
			begin
				waitCount = CBR_WAIT;
				readyUsed = 1'b1;
				readyClk = READY_CLK_CBR;
			end
			KD_MFAULT:
			begin
				waitCount = blockWait[0 +: WAIT_W];
				readyUsed = 1'b1;
			end
			KD_DRAM_OFF:
			begin
				// fly-by dram off-page never goes below the fixed dram minimum
				waitCount = (isFlyby && flyW > dramOff) ? flyW : dramOff;
				readyUsed = 1'b1;
				readyClk = READY_CLK_DRAM_OFF;
			end
			KD_DRAM_ON: waitCount = isFlyby ? flyW : WAIT_W'(dramPageWait);
			KD_PROM_ON: waitCount = isFlyby ? flyW : WAIT_W'(promPageWait);
			KD_PROM_OFF: waitCount = isFlyby ? flyW : blockWait[3*WAIT_W +: WAIT_W];
			KD_INT_IO: waitCount = INT_IO_BASE_WAIT + WAIT_W'(intIoWait);
			KD_SRAM:
			begin
				if (isFlyby)
					waitCount = flyW;
				readyUsed = 1'b1;
			end
			KD_EXT_IO:
			begin
				if (isFlyby)
					waitCount = flyW;
				readyUsed = !isFlyby;
			end
			default: waitCount = '0;
		endcase
	end
endmodule

/* File: verilog/bhl_bus_ctrl.sv */
// bus cycle controller: hold handshake, bus lock, chip selects and wait insertion
`timescale 1ns/1ps
module bhl_bus_ctrl
	import bhl_pkg::*;
#(
	parameter int WAITW = WAIT_W // width of a wait field
)
(
	input wire logic clk, // 20 MHz bus clock
	input wire logic srst, // synchronous reset, active high
	input wire logic ce, // clock enable, freezes everything except synchronous reset when low
	input wire logic holdReqN, // hold request pin, active low
	input wire logic readyN, // ready pin, active low
	input wire logic cycReq, // cpu asks for a bus cycle
	input wire logic [1:0] cycBlock, // address block of the cycle
	input wire logic cycIsIo, // cycle goes to i/o space
	input wire logic cycWrite, // cycle is a write
	input wire logic cycPageHit, // cycle hits the open page
	input wire logic cycCbr, // cbr refresh cycle
	input wire logic cycHaltAck, // halt acknowledge cycle
	input wire logic cycMfault, // machine fault write cycle
	input wire logic cycFlyby, // fly-by dma cycle
	input wire logic cycFlybyCh, // fly-by dma channel
	input wire logic cycDmaTwo, // two-cycle dma cycle
	input wire logic [1:0] srcBlock, // dma source block number
	input wire logic [1:0] dstBlock, // dma destination block number
	input wire logic xchgActive, // interlocked exchange in progress
	input wire logic xchgLast, // current cycle is the exchange's last write
	input wire logic stopMode, // stop mode, internal clock stopped
	input wire logic selfRefresh, // idle-mode self-refresh running
	input wire logic [1:0] ct0, // block 0 cycle type
	input wire logic ct3, // block 3 page-rom select
	input wire logic [4*WAITW-1:0] blockWait, // per-block wait counts
	input wire logic [2*WAITW-1:0] flybyWait, // fly-by wait counts per channel
	input wire logic dramColWait, // extra off-page dram wait
	input wire logic dramPageWait, // extra on-page dram wait
	input wire logic promPageWait, // extra on-page page-rom wait
	input wire logic intIoWait, // extra internal i/o wait
	input wire logic lockOutputSelect, // lock rather than watchdog on shared pin
	input wire logic watchdogTimeoutN, // watchdog timeout, active low
	output logic holdAckOut, // hold acknowledge, active high
	output logic busOe, // address, data and control drive enable
	output logic [3:0] csN, // chip select pins, active low
	output logic csOe, // drive enable of select pins 0-2
	output logic cs3Oe, // drive enable of select pin 3
	output logic memReadN, // memory read strobe, active low
	output logic memReadOe, // memory read strobe drive enable
	output logic rasN, // dram row strobe, active low
	output logic rasOe, // row strobe drive enable
	output logic casN, // both column strobes, active low
	output logic writeN, // write strobe, active low
	output logic strobeOe, // column, write and refresh drive enable
	output logic refreshReqN, // refresh request on shared block 0 pin, active low
	output logic lockPinN, // shared lock / watchdog timeout pin, active low
	output logic selfRefRestart, // one-cycle pulse: begin a new self-refresh
	output logic cycDone // one-cycle pulse: bus cycle ends
);
	// the wait selector is built for the package width only
	if (WAITW != WAIT_W)
	begin : gWidthCheck
		$error("wait field width must match the package");
	end

	// pin synchronisers: s1 feeds only s2; s2 and s3 must agree before a change counts
	logic hldS1_q, hldS2_q, hldS3_q, hldF_q;
	logic rdyS1_q, rdyS2_q, rdyS3_q, rdyF_q;
	logic hldF_d, rdyF_d;

	always_comb
	begin
		hldF_d = (hldS2_q == hldS3_q) ? !hldS3_q : hldF_q;
		rdyF_d = (rdyS2_q == rdyS3_q) ? !rdyS3_q : rdyF_q;
	end

	// kept out of reset so a request during reset still reaches the hold grant
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			hldS1_q <= holdReqN;
			hldS2_q <= hldS1_q;
			hldS3_q <= hldS2_q;
			hldF_q <= hldF_d;
			rdyS1_q <= readyN;
			rdyS2_q <= rdyS1_q;
			rdyS3_q <= rdyS2_q;
			rdyF_q <= rdyF_d;
		end
	end

	bhl_kind_e kind;
	logic [WAIT_W-1:0] selWait;
	logic selReadyUsed;
	logic [T2CNT_W-1:0] selReadyClk;

	bhl_wait_sel u_wait_sel
	(
		.block(cycBlock),
		.isIo(cycIsIo),
		.pageHit(cycPageHit),
		.isCbr(cycCbr),
		.isSelfRef(1'b0),
		.isHaltAck(cycHaltAck),
		.isMfault(cycMfault),
		.isFlyby(cycFlyby),
		.flybyCh(cycFlybyCh),
		.isDmaTwo(cycDmaTwo),
		.isWrite(cycWrite),
		.srcBlock(srcBlock),
		.dstBlock(dstBlock),
		.ct0(ct0),
		.ct3(ct3),
		.blockWait(blockWait),
		.flybyWait(flybyWait),
		.dramColWait(dramColWait),
		.dramPageWait(dramPageWait),
		.promPageWait(promPageWait),
		.intIoWait(intIoWait),
		.kind(kind),
		.waitCount(selWait),
		.readyUsed(selReadyUsed),
		.readyClk(selReadyClk)
	);

	bhl_state_e state_q, state_d;
	bhl_kind_e kind_q, kind_d;
	logic [WAIT_W-1:0] waitCnt_q, waitCnt_d;
	logic [T2CNT_W-1:0] t2Cnt_q, t2Cnt_d;
	logic readyUsed_q, readyUsed_d;
	logic [T2CNT_W-1:0] readyClk_q, readyClk_d;
	logic [1:0] blk_q, blk_d;
	logic io_q, io_d;
	logic wr_q, wr_d;
	logic lock_q, lock_d;
	logic promOpen_q, promOpen_d;
	logic dramOpen_q, dramOpen_d;
	logic [SRCNT_W-1:0] srCnt_q, srCnt_d;
	logic srHeld_q, srHeld_d;
	logic srRelease_q, srRelease_d;
	logic holdBlocked, t2Done, inCycle;

	always_comb
	begin
		// refusal terms; a halt acknowledge cycle counts while it is in progress
		holdBlocked = xchgActive || lock_q || stopMode
			|| ((state_q != ST_IDLE) && kind_q == KD_HALT_ACK)
			|| (selfRefresh && srCnt_q < SELF_REF_HOLD_BLOCK);
		// programmed count must run out and, where it counts, ready must be seen
		t2Done = (waitCnt_q == '0) && (!readyUsed_q || (rdyF_q && t2Cnt_q >= readyClk_q));
		inCycle = (state_q == ST_T1) || (state_q == ST_T2);
		state_d = state_q;
		kind_d = kind_q;
		waitCnt_d = waitCnt_q;
		t2Cnt_d = t2Cnt_q;
		readyUsed_d = readyUsed_q;
		readyClk_d = readyClk_q;
		blk_d = blk_q;
		io_d = io_q;
		wr_d = wr_q;
		lock_d = lock_q;
		promOpen_d = promOpen_q;
		dramOpen_d = dramOpen_q;
		case (state_q)
			ST_IDLE:
			begin
				if (hldF_q && !holdBlocked)
					state_d = ST_HOLD;
				else if (cycReq)
				begin
					state_d = ST_T1;
					kind_d = kind;
					blk_d = cycBlock;
					io_d = cycIsIo;
					wr_d = cycWrite;
					waitCnt_d = selWait;
					readyUsed_d = selReadyUsed;
					readyClk_d = selReadyClk;
					if (xchgActive)
						lock_d = 1'b1;
				end
			end
			ST_T1:
			begin
				state_d = ST_T2;
				t2Cnt_d = T2CNT_W'(1);
			end
			ST_T2:
			begin
				if (t2Done)
				begin
					state_d = ST_IDLE;
					if (lock_q && xchgLast && wr_q)
						lock_d = 1'b0;
					promOpen_d = (kind_q == KD_PROM_ON) || (kind_q == KD_PROM_OFF);
					dramOpen_d = (kind_q == KD_DRAM_ON) || (kind_q == KD_DRAM_OFF);
				end
				else
				begin
					if (waitCnt_q != '0)
						waitCnt_d = waitCnt_q - WAIT_W'(1);
					if (t2Cnt_q != '1)
						t2Cnt_d = t2Cnt_q + T2CNT_W'(1);
				end
			end
			ST_HOLD:
			begin
				if (!hldF_q)
				begin
					state_d = ST_IDLE;
					promOpen_d = 1'b0;
					dramOpen_d = 1'b0;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// self-refresh age for the hold refusal window and the release restart
	always_comb
	begin
		srCnt_d = srCnt_q;
		if (!selfRefresh || srRelease_q)
			srCnt_d = '0;
		else if (srCnt_q < SELF_REF_HOLD_BLOCK && state_q != ST_HOLD)
			srCnt_d = srCnt_q + SRCNT_W'(1);
		srHeld_d = selfRefresh && (state_q == ST_HOLD);
		srRelease_d = srHeld_q && (state_q != ST_HOLD);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			// hold may be granted while reset is held
			state_q <= hldF_q ? ST_HOLD : ST_IDLE;
			kind_q <= KD_SRAM;
			waitCnt_q <= '0;
			t2Cnt_q <= '0;
			readyUsed_q <= 1'b0;
			readyClk_q <= READY_CLK_OTHER;
			blk_q <= 2'h0;
			io_q <= 1'b0;
			wr_q <= 1'b0;
			lock_q <= 1'b0;
			promOpen_q <= 1'b0;
			dramOpen_q <= 1'b0;
			srCnt_q <= '0;
			srHeld_q <= 1'b0;
			srRelease_q <= 1'b0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			kind_q <= kind_d;
			waitCnt_q <= waitCnt_d;
			t2Cnt_q <= t2Cnt_d;
			readyUsed_q <= readyUsed_d;
			readyClk_q <= readyClk_d;
			blk_q <= blk_d;
			io_q <= io_d;
			wr_q <= wr_d;
			lock_q <= lock_d;
			promOpen_q <= promOpen_d;
			dramOpen_q <= dramOpen_d;
			srCnt_q <= srCnt_d;
			srHeld_q <= srHeld_d;
			srRelease_q <= srRelease_d;
		end
	end

	// pin stage: every output straight from a flip-flop
	logic holdAck_d, busOe_d, csOe_d, cs3Oe_d, memReadN_d, memReadOe_d;
	logic rasN_d, rasOe_d, casN_d, writeN_d, strobeOe_d, refreshReqN_d;
	logic lockPinN_d, selfRefRestart_d, cycDone_d;
	logic [3:0] csN_d;
	logic memCyc, selfRefDrive;

	always_comb
	begin
		memCyc = inCycle && (kind_q != KD_CBR) && (kind_q != KD_HALT_ACK);
		selfRefDrive = selfRefresh && !srHeld_q && !srRelease_q;
		holdAck_d = (state_d == ST_HOLD);
		busOe_d = (state_d != ST_HOLD);
		csN_d = RST_CS_N;
		if (memCyc)
		begin
			if (blk_q != 2'h3 || !io_q)
				csN_d[blk_q] = 1'b0;
			if (blk_q == 2'h0 && ct0 == CT0_DRAM_REFRESH_REQUEST_OUT)
				csN_d[0] = 1'b1;
		end
		if (promOpen_q && state_q == ST_IDLE)
			csN_d[3] = 1'b0;
		csOe_d = (state_d != ST_HOLD);
		cs3Oe_d = (state_d != ST_HOLD);
		memReadN_d = !((memCyc && !wr_q && !io_q) || (promOpen_q && state_q == ST_IDLE));
		memReadOe_d = (state_d != ST_HOLD);
		rasN_d = !((dramOpen_q && state_q != ST_HOLD) || selfRefDrive
			|| (memCyc && (kind_q == KD_DRAM_ON || kind_q == KD_DRAM_OFF)));
		rasOe_d = (state_d != ST_HOLD);
		casN_d = !(selfRefDrive || (state_q == ST_T2
			&& (kind_q == KD_DRAM_ON || kind_q == KD_DRAM_OFF || kind_q == KD_CBR)));
		writeN_d = !(memCyc && wr_q);
		strobeOe_d = (state_d != ST_HOLD);
		refreshReqN_d = !(ct0 == CT0_DRAM_REFRESH_REQUEST_OUT && (selfRefDrive || (inCycle && kind_q == KD_CBR)));
		if (ct0 == CT0_DRAM_REFRESH_REQUEST_OUT)
			csN_d[0] = refreshReqN_d;
		lockPinN_d = lockOutputSelect ? !lock_d : watchdogTimeoutN;
		selfRefRestart_d = srRelease_q && selfRefresh;
		cycDone_d = (state_q == ST_T2) && t2Done;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			// a hold granted under reset must reach the pins too, not only the state
			holdAckOut <= hldF_q;
			busOe <= !hldF_q;
			csN <= RST_CS_N;
			csOe <= !hldF_q;
			cs3Oe <= !hldF_q;
			memReadN <= RST_STROBE_N;
			memReadOe <= !hldF_q;
			rasN <= RST_STROBE_N;
			rasOe <= !hldF_q;
			casN <= RST_STROBE_N;
			writeN <= RST_STROBE_N;
			strobeOe <= !hldF_q;
			refreshReqN <= RST_STROBE_N;
			lockPinN <= RST_STROBE_N;
			selfRefRestart <= 1'b0;
			cycDone <= 1'b0;
		end
		else if (ce)
		begin
			holdAckOut <= holdAck_d;
			busOe <= busOe_d;
			csN <= csN_d;
			csOe <= csOe_d;
			cs3Oe <= cs3Oe_d;
			memReadN <= memReadN_d;
			memReadOe <= memReadOe_d;
			rasN <= rasN_d;
			rasOe <= rasOe_d;
			casN <= casN_d;
			writeN <= writeN_d;
			strobeOe <= strobeOe_d;
			refreshReqN <= refreshReqN_d;
			lockPinN <= lockPinN_d;
			selfRefRestart <= selfRefRestart_d;
			cycDone <= cycDone_d;
		end
	end
endmodule

/* File: verif/bhl_props.sv */
// concurrent checks on the bus controller ports
`timescale 1ns/1ps
module bhl_props
(
	input wire logic clk, // bus clock
	input wire logic srst, // sync reset
	input wire logic stopMode, // stop mode
	input wire logic selfRefresh, // self-refresh running
	input wire logic xchgActive, // exchange running
	input wire logic lockOutputSelect, // lock shown on shared pin
	input wire logic watchdogTimeoutN, // watchdog timeout
	input wire logic holdAckOut, // hold acknowledge
	input wire logic busOe, // bus drive enable
	input wire logic csOe, // select drive enable
	input wire logic strobeOe, // strobe drive enable
	input wire logic [3:0] csN, // chip selects
	input wire logic memReadN, // read strobe
	input wire logic rasN, // row strobe
	input wire logic casN, // column strobes
	input wire logic writeN, // write strobe
	input wire logic lockPinN, // shared lock pin
	input wire logic selfRefRestart, // self-refresh restart
	input wire logic cycDone // cycle end
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_hold_floats: assert property (holdAckOut |-> !busOe && !csOe && !strobeOe)
		else $error("bus driven during hold");
	a_release_drives: assert property ($fell(holdAckOut) |-> busOe && csOe && strobeOe)
		else $error("bus not driven after hold");
	a_no_cycle_hold: assert property (holdAckOut |-> !cycDone)
		else $error("cycle ended during hold");
	a_hold_refused: assert property ($rose(holdAckOut) |-> !$past(stopMode) && !$past(xchgActive))
		else $error("hold granted while blocked");
	a_lock_no_hold: assert property (lockOutputSelect && !lockPinN |=> !$rose(holdAckOut))
		else $error("hold granted while locked");
	a_pin_watchdog: assert property (!$past(srst) && !$past(lockOutputSelect) |-> lockPinN == $past(watchdogTimeoutN))
		else $error("shared pin not showing watchdog");
	a_cs_single: assert property ($onehot0(~csN))
		else $error("more than one select active");
	a_done_gap: assert property (cycDone |=> !cycDone [*2])
		else $error("cycles closer than allowed");
	a_release_idle: assert property ($fell(holdAckOut) |-> rasN && casN && writeN && memReadN && csN == 4'hF)
		else $error("strobes active on hold release");
	a_sr_restart: assert property ($fell(holdAckOut) && selfRefresh |-> ##[0:2] selfRefRestart)
		else $error("self-refresh not restarted");

	c_hold: cover property ($rose(holdAckOut));
	c_lock: cover property (cycDone && !lockPinN && lockOutputSelect);
	c_restart: cover property (selfRefRestart);
endmodule

bind bhl_bus_ctrl bhl_props i_bhl_props (.clk(clk), .srst(srst), .stopMode(stopMode), .selfRefresh(selfRefresh),
	.xchgActive(xchgActive), .lockOutputSelect(lockOutputSelect), .watchdogTimeoutN(watchdogTimeoutN),
	.holdAckOut(holdAckOut), .busOe(busOe), .csOe(csOe), .strobeOe(strobeOe), .csN(csN), .memReadN(memReadN),
	.rasN(rasN), .casN(casN), .writeN(writeN), .lockPinN(lockPinN), .selfRefRestart(selfRefRestart),
	.cycDone(cycDone));

/* File: verif/bhl_master_model.sv */
// outside bus master that asks for the bus on command
`timescale 1ns/1ps
module bhl_master_model
(
	input wire logic clk, // bus clock
	input wire logic srst, // processor reset
	input wire logic want, // bench asks for the bus
	output logic holdReqN // hold request pin, active low
);
	logic up = 1'b0;
	int gap = 3;
	initial holdReqN = 1'b1;
	always @(posedge clk)
	begin
		if (!srst)
			up <= 1'b1;
		gap <= holdReqN ? gap + 1 : 0;
		// quiet until the first reset ends, and idle at least four clocks between holds
		if (!up || (holdReqN && gap < 3))
			holdReqN <= 1'b1;
		else
			holdReqN <= !want;
	end
endmodule

/* File: verif/bhl_bus_ctrl_bench.sv */
// self-checking bench for the bus hold, lock and wait controller
`timescale 1ns/1ps
module bhl_bus_ctrl_bench import bhl_pkg::*;;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic readyN = 1'b0;
	logic cycReq = 1'b0;
	logic want = 1'b0;
	logic lockOutputSelect = 1'b0;
	logic watchdogTimeoutN = 1'b1;
	logic ct3 = 1'b0;
	logic [1:0] cycBlock = 2'h0;
	logic [1:0] ct0 = 2'h0;
	logic [8:0] fl = 9'h000;
	logic [3:0] md = 4'h0;
	logic [3:0] cf = 4'h0;
	logic [4*WAIT_W-1:0] bw = 12'h000;
	logic [2*WAIT_W-1:0] fw = 6'h00;
	logic holdReqN, holdAckOut, busOe, csOe, memReadN, rasN, casN, writeN, strobeOe, lockPinN, selfRefRestart, cycDone;
	logic [3:0] csN;
	logic [31:0] cyc = 32'h0;
	logic [31:0] expQ[$];
	logic [31:0] expNow;
	int bad_count = 0;
	int n_checks = 0;
	int seed = 89;

	always #25 clk = ~clk;

	bhl_master_model i_bhl_master_model (.clk(clk), .srst(srst), .want(want), .holdReqN(holdReqN));

	bhl_bus_ctrl #(.WAITW(WAIT_W)) i_bhl_bus_ctrl (
		.clk(clk), .srst(srst), .ce(1'b1), .holdReqN(holdReqN), .readyN(readyN), .cycReq(cycReq),
		.cycBlock(cycBlock), .cycIsIo(fl[0]), .cycWrite(fl[1]), .cycPageHit(fl[2]), .cycCbr(fl[3]),
		.cycHaltAck(fl[4]), .cycMfault(fl[5]), .cycFlyby(fl[6]), .cycDmaTwo(fl[7]), .cycFlybyCh(fl[8]),
		.srcBlock(2'h1), .dstBlock(2'h2), .xchgActive(md[3]), .xchgLast(md[2]), .stopMode(md[1]),
		.selfRefresh(md[0]), .ct0(ct0), .ct3(ct3), .blockWait(bw), .flybyWait(fw), .dramColWait(cf[3]),
		.dramPageWait(cf[2]), .promPageWait(cf[1]), .intIoWait(cf[0]), .lockOutputSelect(lockOutputSelect),
		.watchdogTimeoutN(watchdogTimeoutN), .holdAckOut(holdAckOut), .busOe(busOe), .csN(csN), .csOe(csOe),
		.cs3Oe(), .memReadN(memReadN), .memReadOe(), .rasN(rasN), .rasOe(), .casN(casN), .writeN(writeN),
		.strobeOe(strobeOe), .refreshReqN(), .lockPinN(lockPinN), .selfRefRestart(selfRefRestart),
		.cycDone(cycDone));

	task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ready is settled before the request so that its synchroniser lag cannot stretch the cycle
	task runCyc(input logic [1:0] blk, input logic [8:0] f, input logic [2:0] w, input logic rdy);
		int k;
		logic [3:0] cs;
		readyN <= rdy;
		repeat (6) @(posedge clk);
		// no select for refresh, halt acknowledge, internal i/o, or block 0 used as refresh request
		cs = 4'hF;
		if (!f[3] && !f[4] && !(blk == 2'h3 && f[0]) && !(blk == 2'h0 && ct0 == CT0_DRAM_REFRESH_REQUEST_OUT))
			cs[blk] = 1'b0;
		cycBlock <= blk;
		fl <= f;
		cycReq <= 1'b1;
		expQ.push_back({cs, 28'(cyc + 32'd4 + 32'(w))});
		@(posedge clk);
		cycReq <= 1'b0;
		k = 0;
		while (cycDone !== 1'b1 && k < 40)
		begin
			@(posedge clk);
			k++;
		end
		@(posedge clk);
	endtask

	task holdExp(input logic v);
		int k;
		k = 0;
		while (holdAckOut !== v && k < 16)
		begin
			@(posedge clk);
			k++;
		end
		check("hold acknowledge", holdAckOut, v);
		check("bus drive", busOe, !v);
	endtask

	always @(posedge clk)
		if (!srst && cycDone === 1'b1)
		begin
			if (expQ.size() == 0)
				check("unexpected cycle end", cyc, 32'h0);
			else
			begin
				expNow = expQ.pop_front();
				check("cycle end", cyc, {4'h0, expNow[27:0]});
				check("chip select", 32'(csN), 32'(expNow[31:28]));
			end
		end

	always @(posedge clk)
		watchdogTimeoutN <= 1'($random(seed));

	always @(posedge clk)
	begin
		cyc <= cyc + 32'd1;
		if (cyc == 32'd6000)
		begin
			bad_count++;
			test_done();
		end
	end

	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		for (int r = 0; r < 3; r++)
		begin
			bw <= 12'($random(seed));
			fw <= 6'($random(seed));
			cf <= 4'($random(seed));
			@(posedge clk);
			for (int b = 0; b < 4; b++)
				runCyc(2'(b), 9'h000, bw[3*b +: 3], 1'b0);
			runCyc(2'h0, 9'h010, 3'h0, 1'b1);
			runCyc(2'h0, 9'h008, 3'h3, 1'b0);
			runCyc(2'h0, 9'h023, bw[2:0], 1'b0);
			runCyc(2'h3, 9'h001, 3'h1 + 3'(cf[0]), 1'b1);
			runCyc(2'h0, 9'h080, bw[5:3], 1'b0);
			runCyc(2'h0, 9'h082, bw[8:6], 1'b0);
			runCyc(2'h1, 9'h040, fw[2:0], 1'b0);
			runCyc(2'h1, 9'h140, fw[5:3], 1'b0);
			// ready held off into the wait states: the later of ready and the count ends the cycle
			fork
				runCyc(2'h2, 9'h000, (bw[8:6] > 3'h5) ? bw[8:6] : 3'h5, 1'b1);
				begin
					repeat (9) @(posedge clk);
					readyN <= 1'b0;
				end
			join
			ct0 <= 2'h1;
			runCyc(2'h0, 9'h000, 3'h2 + 3'(cf[3]), 1'b0);
			runCyc(2'h0, 9'h040, (fw[2:0] > 3'h2 + 3'(cf[3])) ? fw[2:0] : 3'h2 + 3'(cf[3]), 1'b0);
			runCyc(2'h0, 9'h004, 3'(cf[2]), 1'b1);
			ct0 <= 2'h3;
			runCyc(2'h0, 9'h001, bw[2:0], 1'b0);
			ct0 <= 2'h0;
			ct3 <= 1'b1;
			runCyc(2'h3, 9'h000, bw[11:9], 1'b1);
			runCyc(2'h3, 9'h004, 3'(cf[1]), 1'b1);
			ct3 <= 1'b0;
		end
		lockOutputSelect <= 1'b1;
		md <= 4'h8;
		runCyc(2'h1, 9'h000, bw[5:3], 1'b0);
		check("lock pin", lockPinN, 1'b0);
		md <= 4'hC;
		runCyc(2'h1, 9'h002, bw[5:3], 1'b0);
		@(posedge clk);
		check("lock pin", lockPinN, 1'b1);
		md <= 4'h0;
		lockOutputSelect <= 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			md <= i ? 4'h8 : 4'h2;
			want <= 1'b1;
			repeat (14) @(posedge clk);
			check("refused hold", holdAckOut, 1'b0);
			md <= 4'h0;
			holdExp(1'b1);
			want <= 1'b0;
			holdExp(1'b0);
		end
		md <= 4'h1;
		want <= 1'b1;
		// the filtered request is up one clock before the sixth self-refresh clock has passed
		repeat (7) @(posedge clk);
		check("refused hold", holdAckOut, 1'b0);
		holdExp(1'b1);
		want <= 1'b0;
		holdExp(1'b0);
		repeat (2) @(posedge clk);
		check("self-refresh restart", selfRefRestart, 1'b1);
		@(posedge clk);
		md <= 4'h0;
		want <= 1'b1;
		holdExp(1'b1);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		check("hold in reset", holdAckOut, 1'b1);
		srst <= 1'b0;
		want <= 1'b0;
		holdExp(1'b0);
		check("pending cycle ends", 32'(expQ.size()), 32'h0);
		test_done();
	end
endmodule
